// ---- core/hdm_monitor.sv ----
// Harmonic distortion alarm monitor with an AXI4-Lite register slave.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: Operating mode on, blocked, test, test-blocked or off; resets to on.
// RQ2: Static select chooses current module one or two; defaults to one.
// RQ3: One static choice of amplitude or power ratio; amplitude by default.
// RQ4: Mode, module select and ratio method are outside setting groups.
// RQ5: Each of phase, residual one, residual two alarms only when enabled.
// RQ6: Picked-up element releases only below 97 percent of its threshold.
// RQ7: One phase threshold; any one, two or three phases pick up.
// RQ8: Phase path needs some phase strictly above the threshold.
// RQ9: Phase threshold in 0.01 percent steps, default 10.00 percent.
// RQ10: Residual one threshold, 0.01 percent steps, default 10.00 percent.
// RQ11: Residual two threshold, 0.01 percent steps, default 10.00 percent.
// RQ12: Blocking input sampled at the start of every processing cycle.
// RQ13: Pick-up without blocking raises start and runs the delay.
// RQ14: Pick-up under blocking raises blocked and nothing else.
// RQ15: Blocking after start clears start as a pick-up release would.
// RQ16: Blocking source asserts at least 5 ms before the delay expires.
// RQ17: Only definite-time delays are used.
// RQ18: Phase alarm delay in 5 ms steps, default 10 s.
// RQ19: Residual one alarm delay in 5 ms steps, default 10 s.
// RQ20: Residual two alarm delay in 5 ms steps, default 10 s.
// RQ21: Status shows normal, start, alarm or blocked and the mode.
// RQ22: Thresholds, enables and delays change live without restart.
// RQ23: Spectral magnitudes arrive per channel every 5 ms cycle.
// RQ24: Distortion uses 32 components as amplitude or power ratio; the code takes harmonic orders 1 to 31 only.
// RQ25: Alarm after start held for the delay; cleared with start.
// RQ26: Off mode keeps all indications low and status normal.
module hdm_monitor
  import hdm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire hdm_meas_t meas_one,
  input wire hdm_meas_t meas_two,
  input wire logic cycle_tick,
  input wire logic block_in,
  output hdm_ind_t ind,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Merges a write into a register under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] stb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (stb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Compares distortion with a limit in parts per million: {above, below}.
  function automatic logic [1:0] cmp(input logic [36:0] hs,
                                     input logic [31:0] fs,
                                     input logic [19:0] lim,
                                     input logic pwr);
    logic [79:0] lhs;
    logic [79:0] rhs;
    lhs = 80'(hs) * (pwr ? HDM_K_PWR : HDM_K_AMP); // [RQ24]
    rhs = pwr ? 80'(lim) * 80'(fs) : 80'(lim) * 80'(lim) * 80'(fs); // [RQ3]
    return {lhs > rhs, lhs < rhs};
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  hdm_mode_t mode_r;
  logic sel_r;
  logic pwr_r;
  logic [2:0] ena_r;
  logic [HDM_THR_W-1:0] thr_r [HDM_NCH];
  logic [HDM_DLY_W-1:0] dly_r [HDM_NCH];
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Static and group settings; group values apply at the next cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    logic [31:0] m;
    if (!arst_n) begin
      mode_r <= HDM_MODE_ON; // [RQ1]
      sel_r <= 1'b0; // [RQ2]
      pwr_r <= 1'b0; // [RQ3]
      ena_r <= HDM_ENA_RST; // [RQ5]
      for (int c = 0; c < HDM_NCH; c++) begin
        thr_r[c] <= HDM_THR_RST; // [RQ9] [RQ10] [RQ11]
        dly_r[c] <= HDM_DLY_RST; // [RQ18] [RQ19] [RQ20]
      end
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      m = 32'h0000_0000;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        unique case (awaddr_r & 8'hFC)
          HDM_OFS_CTRL: begin
            m = merge({23'h0, pwr_r, 3'h0, sel_r, 1'b0, mode_r},
                      wdata_r, wstrb_r);
            if (m[HDM_POS_MODE +: 3] inside {HDM_MODE_ON, HDM_MODE_BLK,
                HDM_MODE_TEST, HDM_MODE_TBLK, HDM_MODE_OFF}) begin
              mode_r <= hdm_mode_t'(m[HDM_POS_MODE +: 3]); // [RQ1] [RQ4]
            end
            sel_r <= m[HDM_POS_SEL]; // [RQ2] [RQ4]
            pwr_r <= m[HDM_POS_PWR]; // [RQ3] [RQ4]
          end
          HDM_OFS_ENA: begin
            m = merge({29'h0, ena_r}, wdata_r, wstrb_r);
            ena_r <= m[2:0]; // [RQ5] [RQ22]
          end
          HDM_OFS_THR_PH, HDM_OFS_THR_R1, HDM_OFS_THR_R2: begin
            for (int c = 0; c < HDM_NCH; c++) begin
              if ((awaddr_r & 8'hFC) == HDM_OFS_THR_PH + 8'(4 * c)) begin
                m = merge({18'h0, thr_r[c]}, wdata_r, wstrb_r);
                thr_r[c] <= m[HDM_THR_W-1:0]; // [RQ22]
              end
            end
          end
          HDM_OFS_DLY_PH, HDM_OFS_DLY_R1, HDM_OFS_DLY_R2: begin
            for (int c = 0; c < HDM_NCH; c++) begin
              if ((awaddr_r & 8'hFC) == HDM_OFS_DLY_PH + 8'(4 * c)) begin
                m = merge({13'h0, dly_r[c]}, wdata_r, wstrb_r);
                dly_r[c] <= m[HDM_DLY_W-1:0]; // [RQ17] [RQ22]
              end
            end
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode.
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr[7:0] & 8'hFC)
      HDM_OFS_CTRL: rd_word = {23'h0, pwr_r, 3'h0, sel_r, 1'b0, mode_r};
      HDM_OFS_ENA: rd_word = {29'h0, ena_r};
      HDM_OFS_THR_PH: rd_word = {18'h0, thr_r[0]};
      HDM_OFS_THR_R1: rd_word = {18'h0, thr_r[1]};
      HDM_OFS_THR_R2: rd_word = {18'h0, thr_r[2]};
      HDM_OFS_DLY_PH: rd_word = {13'h0, dly_r[0]};
      HDM_OFS_DLY_R1: rd_word = {13'h0, dly_r[1]};
      HDM_OFS_DLY_R2: rd_word = {13'h0, dly_r[2]};
      HDM_OFS_STAT: rd_word = {20'h0, ind.mode, ind.cond, ind.blocked,
                               ind.alarm, ind.start}; // [RQ21]
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Spectral accumulation per processing cycle
  // ----------------------------------------------------------------------
  hdm_meas_t mi;
  logic [36:0] hacc_r [5];
  logic [31:0] facc_r [5];
  logic [36:0] hsnap_r [5];
  logic [31:0] fsnap_r [5];
  logic blk_s_r;
  logic eval_r;

  assign mi = sel_r ? meas_two : meas_one; // [RQ2]

  generate
    for (genvar k = 0; k < 5; k++) begin : g_acc
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          hacc_r[k] <= 37'h0;
          facc_r[k] <= 32'h0000_0000;
          hsnap_r[k] <= 37'h0;
          fsnap_r[k] <= 32'h0000_0000;
        end else if (cycle_tick) begin // [RQ23]
          hsnap_r[k] <= hacc_r[k];
          fsnap_r[k] <= facc_r[k];
          hacc_r[k] <= 37'h0;
          facc_r[k] <= 32'h0000_0000;
        end else if (mi.valid && mi.chan == 3'(k)) begin
          if (mi.harm == 5'h01) begin
            facc_r[k] <= 32'(mi.mag) * 32'(mi.mag);
          end else if (mi.harm >= 5'h02) begin
            hacc_r[k] <= hacc_r[k] + 37'(32'(mi.mag) * 32'(mi.mag)); // [RQ24]
          end
        end
      end
    end
  endgenerate

  // Blocking is caught once at the start of each processing cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      blk_s_r <= 1'b0;
      eval_r <= 1'b0;
    end else begin
      eval_r <= cycle_tick;
      if (cycle_tick) begin
        blk_s_r <= block_in || mode_r == HDM_MODE_BLK
                   || mode_r == HDM_MODE_TBLK; // [RQ12] [RQ1]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pick-up, blocking and definite-time alarm per alarm channel
  // ----------------------------------------------------------------------
  logic [2:0] pu_r;
  logic [2:0] pu_nxt;
  logic [2:0] st_r;
  logic [2:0] al_r;
  logic [2:0] bk_r;
  logic [HDM_DLY_W-1:0] tmr_r [HDM_NCH];

  always_comb begin
    logic [1:0] hi;
    logic [1:0] lo;
    pu_nxt = 3'h0;
    hi = 2'b00;
    lo = 2'b00;
    for (int p = 0; p < 3; p++) begin
      hi = cmp(hsnap_r[p], fsnap_r[p], 20'(thr_r[0] * HDM_PICK_PCT), pwr_r);
      lo = cmp(hsnap_r[p], fsnap_r[p], 20'(thr_r[0] * HDM_DROP_PCT), pwr_r);
      pu_nxt[0] = pu_nxt[0] || (pu_r[0] ? !lo[0] : hi[1]); // [RQ7] [RQ8]
    end
    for (int c = 1; c < HDM_NCH; c++) begin
      hi = cmp(hsnap_r[c+2], fsnap_r[c+2], 20'(thr_r[c] * HDM_PICK_PCT),
               pwr_r);
      lo = cmp(hsnap_r[c+2], fsnap_r[c+2], 20'(thr_r[c] * HDM_DROP_PCT),
               pwr_r);
      pu_nxt[c] = pu_r[c] ? !lo[0] : hi[1]; // [RQ6] [RQ10] [RQ11]
    end
    pu_nxt = pu_nxt & ena_r; // [RQ5]
  end

  generate
    for (genvar c = 0; c < HDM_NCH; c++) begin : g_ch
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          pu_r[c] <= 1'b0;
          st_r[c] <= 1'b0;
          al_r[c] <= 1'b0;
          bk_r[c] <= 1'b0;
          tmr_r[c] <= '0;
        end else if (mode_r == HDM_MODE_OFF) begin // [RQ26]
          pu_r[c] <= 1'b0;
          st_r[c] <= 1'b0;
          al_r[c] <= 1'b0;
          bk_r[c] <= 1'b0;
          tmr_r[c] <= '0;
        end else if (eval_r) begin
          pu_r[c] <= pu_nxt[c];
          if (pu_nxt[c] && !blk_s_r) begin // [RQ13]
            st_r[c] <= 1'b1;
            bk_r[c] <= 1'b0;
            al_r[c] <= tmr_r[c] >= dly_r[c]; // [RQ25] [RQ17]
            if (tmr_r[c] < dly_r[c]) begin
              tmr_r[c] <= tmr_r[c] + 1'b1;
            end
          end else begin // [RQ14] [RQ15]
            st_r[c] <= 1'b0;
            al_r[c] <= 1'b0;
            bk_r[c] <= pu_nxt[c];
            tmr_r[c] <= '0;
          end
        end
      end
    end
  endgenerate

  // Outputs straight from flip-flops.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ind <= '{start: 3'h0, alarm: 3'h0, blocked: 1'b0,
               cond: HDM_COND_NORMAL, mode: HDM_MODE_ON};
    end else begin
      ind.start <= st_r;
      ind.alarm <= al_r;
      ind.blocked <= |bk_r;
      ind.mode <= mode_r; // [RQ21]
      if (|bk_r) begin
        ind.cond <= HDM_COND_BLOCKED;
      end else if (|al_r) begin
        ind.cond <= HDM_COND_ALARM;
      end else if (|st_r) begin
        ind.cond <= HDM_COND_START;
      end else begin
        ind.cond <= HDM_COND_NORMAL;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_off_quiet;
    @(posedge clock) disable iff (!arst_n)
      mode_r == HDM_MODE_OFF |=> ##1 (ind.start == 3'h0
        && ind.alarm == 3'h0 && !ind.blocked
        && ind.cond == HDM_COND_NORMAL);
  endproperty
  a_off_quiet: assert property (p_off_quiet) // [RQ26]
    else $error("indication active in off mode");

  property p_ena_gate;
    @(posedge clock) disable iff (!arst_n)
      eval_r && !ena_r[0] |=> !st_r[0] && !al_r[0] && !bk_r[0];
  endproperty
  a_ena_gate: assert property (p_ena_gate) // [RQ5]
    else $error("disabled phase channel became active");

  property p_alarm_needs_start;
    @(posedge clock) disable iff (!arst_n)
      al_r != 3'h0 |-> (al_r & ~st_r) == 3'h0;
  endproperty
  a_alarm_needs_start: assert property (p_alarm_needs_start) // [RQ25]
    else $error("alarm without start");

  property p_block_clears;
    @(posedge clock) disable iff (!arst_n)
      eval_r && blk_s_r && mode_r != HDM_MODE_OFF
      |=> st_r == 3'h0 && al_r == 3'h0 && bk_r == pu_r;
  endproperty
  a_block_clears: assert property (p_block_clears) // [RQ14] [RQ15]
    else $error("start survived blocking");

  property p_start_on_pick;
    @(posedge clock) disable iff (!arst_n)
      eval_r && !blk_s_r && pu_nxt[1] && mode_r != HDM_MODE_OFF
      |=> st_r[1] && !bk_r[1] ##2 ind.start[1];
  endproperty
  a_start_on_pick: assert property (p_start_on_pick) // [RQ13]
    else $error("pick-up did not raise start");

  property p_tick_eval;
    @(posedge clock) disable iff (!arst_n)
      cycle_tick && !$past(cycle_tick) |=> eval_r
        && blk_s_r == $past(block_in || mode_r == HDM_MODE_BLK
                            || mode_r == HDM_MODE_TBLK);
  endproperty
  a_tick_eval: assert property (p_tick_eval) // [RQ12]
    else $error("blocking not sampled at cycle start");

  property p_zero_delay;
    @(posedge clock) disable iff (!arst_n)
      eval_r && !blk_s_r && pu_nxt[2] && dly_r[2] == '0
      && mode_r != HDM_MODE_OFF |=> al_r[2];
  endproperty
  a_zero_delay: assert property (p_zero_delay) // [RQ25]
    else $error("zero delay alarm late");

  property p_cond_map;
    @(posedge clock) disable iff (!arst_n)
      ind.blocked |-> ind.cond == HDM_COND_BLOCKED;
  endproperty
  a_cond_map: assert property (p_cond_map) // [RQ21]
    else $error("status does not show blocked");

  property p_bresp_hold;
    @(posedge clock) disable iff (!arst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped early");

  property p_mode_readback;
    @(posedge clock) disable iff (!arst_n)
      $changed(mode_r) |=> ind.mode == $past(mode_r);
  endproperty
  a_mode_readback: assert property (p_mode_readback) // [RQ1]
    else $error("mode readback stale");

  c_alarm: cover property (@(posedge clock) disable iff (!arst_n)
    $rose(ind.alarm[0]));
  c_blocked: cover property (@(posedge clock) disable iff (!arst_n)
    $rose(ind.blocked));
  c_release: cover property (@(posedge clock) disable iff (!arst_n)
    $fell(ind.start[2]));
endmodule // hdm_monitor
`default_nettype wire

// ---- pkg/hdm_pkg.sv ----
// Package with the types and constants of the distortion alarm monitor.
package hdm_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] HDM_OFS_CTRL = 8'h00;
  localparam logic [7:0] HDM_OFS_ENA = 8'h04;
  localparam logic [7:0] HDM_OFS_THR_PH = 8'h08;
  localparam logic [7:0] HDM_OFS_THR_R1 = 8'h0C;
  localparam logic [7:0] HDM_OFS_THR_R2 = 8'h10;
  localparam logic [7:0] HDM_OFS_DLY_PH = 8'h14;
  localparam logic [7:0] HDM_OFS_DLY_R1 = 8'h18;
  localparam logic [7:0] HDM_OFS_DLY_R2 = 8'h1C;
  localparam logic [7:0] HDM_OFS_STAT = 8'h20;
  // Control field positions.
  localparam int HDM_POS_MODE = 0;
  localparam int HDM_POS_SEL = 4;
  localparam int HDM_POS_PWR = 8;
  // ----------------------------------------------------------------------
  // Settings: thresholds in 0.01 % steps, delays in 5 ms steps
  // ----------------------------------------------------------------------
  localparam int HDM_THR_W = 14;
  localparam int HDM_DLY_W = 19;
  localparam logic [13:0] HDM_THR_RST = 14'h03E8;
  localparam int HDM_DLY_STEP_MS = 5;
  localparam int HDM_DLY_RST_MS = 10000;
  localparam logic [18:0] HDM_DLY_RST = 19'(HDM_DLY_RST_MS / HDM_DLY_STEP_MS);
  localparam logic [2:0] HDM_ENA_RST = 3'h7;
  localparam logic [6:0] HDM_PICK_PCT = 7'h64;
  localparam logic [6:0] HDM_DROP_PCT = 7'h61;
  localparam logic [79:0] HDM_K_PWR = 80'h0000_0000_0000_000F_4240;
  localparam logic [79:0] HDM_K_AMP = 80'h0000_0000_00E8_D4A5_1000;
  localparam int HDM_NCH = 3;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HDM_MODE_ON = 3'h0,
    HDM_MODE_BLK = 3'h1,
    HDM_MODE_TEST = 3'h3,
    HDM_MODE_TBLK = 3'h2,
    HDM_MODE_OFF = 3'h6
  } hdm_mode_t;
  typedef enum logic [1:0] {
    HDM_COND_NORMAL = 2'h0,
    HDM_COND_START = 2'h1,
    HDM_COND_ALARM = 2'h3,
    HDM_COND_BLOCKED = 2'h2
  } hdm_cond_t;
  // One spectral component from a current measurement module.
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [4:0] harm;
    logic [15:0] mag;
  } hdm_meas_t;
  // Indications towards the rest of the device.
  typedef struct packed {
    logic [2:0] start;
    logic [2:0] alarm;
    logic blocked;
    hdm_cond_t cond;
    hdm_mode_t mode;
  } hdm_ind_t;
endpackage

// ---- tb/hdm_front_end.sv ----
// Measurement front end model: one frame of components, then a cycle tick.
`timescale 1ns/1ps
`default_nettype none
module hdm_front_end
  import hdm_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic sel,
  input wire logic [79:0] hm,
  output hdm_meas_t m_one,
  output hdm_meas_t m_two,
  output logic tick,
  output logic done
);
  logic [4:0] st_r;
  hdm_meas_t it;
  initial begin
    st_r = '0;
    m_one = '0;
    m_two = '0;
    tick = 1'b0;
    done = 1'b0;
  end
  // Odd steps carry the fundamental, even steps the second harmonic.
  always_comb begin
    it.valid = 1'b1;
    it.chan = 3'((st_r - 5'h01) >> 1);
    it.harm = st_r[0] ? 5'h01 : 5'h02;
    it.mag = st_r[0] ? 16'h03E8 : hm[16 * int'(it.chan[2:0] % 5) +: 16];
  end
  // The idle module shows changing junk so no stale value looks valid.
  always @(posedge clock) begin
    tick <= st_r == 5'h0B;
    done <= st_r == 5'h10;
    m_one <= {1'b0, ~m_one[23:0]};
    m_two <= {1'b0, ~m_two[23:0]};
    if (st_r != 5'h00 && st_r < 5'h0B) begin
      if (sel) m_two <= it;
      else m_one <= it;
    end
    if (st_r == 5'h10) st_r <= 5'h00;
    else if (st_r != 5'h00 || go) st_r <= st_r + 5'h01;
  end
endmodule // hdm_front_end
`default_nettype wire

// ---- tb/harmonic_distortion_alarm_monitor_test.sv ----
// Self-checking bench of the harmonic distortion alarm monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module harmonic_distortion_alarm_monitor_test
  import hdm_pkg::*;
;
  logic clock = 1'b0, arst_n = 1'b0, go = 1'b0, sel = 1'b0, blk = 1'b0;
  logic [79:0] hm = '0;
  hdm_meas_t m1, m2;
  logic tick, done;
  hdm_ind_t ind;
  hdm_mode_t md = HDM_MODE_ON;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic [1:0] s_axi_bresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #2.5 clock = ~clock;
  hdm_front_end FE (.clock, .go, .sel, .hm, .m_one(m1), .m_two(m2),
    .tick, .done);
  hdm_monitor DUT (
    .clock, .arst_n, .meas_one(m1), .meas_two(m2), .cycle_tick(tick),
    .block_in(blk), .ind, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, {a > HDM_OFS_DLY_R2, 1'b0})
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, r)
  endtask
  // One processing cycle; phases one and three share a value.
  task automatic fr(input logic [15:0] p, q, r, s, input logic [5:0] sa,
    input hdm_cond_t c);
    @(posedge clock);
    hm <= {s, r, p, q, p};
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do @(posedge clock); while (done !== 1'b1);
    `CHK(ind, {sa, c == HDM_COND_BLOCKED, c, md})
  endtask
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(HDM_OFS_CTRL, '0, 2'h0);
    rd(HDM_OFS_ENA, 32'h0000_0007, 2'h0);
    rd(HDM_OFS_THR_PH, 32'h0000_03E8, 2'h0);
    rd(HDM_OFS_THR_R1, 32'h0000_03E8, 2'h0);
    rd(HDM_OFS_THR_R2, 32'h0000_03E8, 2'h0);
    rd(HDM_OFS_DLY_PH, 32'h0000_07D0, 2'h0);
    rd(HDM_OFS_DLY_R1, 32'h0000_07D0, 2'h0);
    rd(HDM_OFS_DLY_R2, 32'h0000_07D0, 2'h0);
    rd(HDM_OFS_STAT, '0, 2'h0);
    rd(8'h24, '0, 2'h2);
    wr(8'h24, 32'hFFFF_FFFF);
    wr(HDM_OFS_DLY_PH, 32'h0000_0002);
    wr(HDM_OFS_DLY_R1, '0);
    wr(HDM_OFS_DLY_R2, '0);
    fr(16'h0064, 16'h0064, '0, '0, 6'h00, HDM_COND_NORMAL);
    fr('0, 16'h0065, '0, '0, 6'h08, HDM_COND_START);
    fr('0, 16'h0065, '0, '0, 6'h08, HDM_COND_START);
    fr('0, 16'h0065, '0, '0, 6'h09, HDM_COND_ALARM);
    rd(HDM_OFS_STAT, 32'h0000_0189, 2'h0);
    fr('0, 16'h0061, '0, '0, 6'h09, HDM_COND_ALARM);
    fr('0, 16'h0060, '0, '0, 6'h00, HDM_COND_NORMAL);
    wr(HDM_OFS_ENA, 32'h0000_0005);
    fr('0, '0, 16'h00C8, 16'h00C8, 6'h24, HDM_COND_ALARM);
    wr(HDM_OFS_ENA, 32'h0000_0007);
    wr(HDM_OFS_THR_R2, 32'h0000_09C4);
    fr('0, '0, 16'h00C8, 16'h00C8, 6'h12, HDM_COND_ALARM);
    fr(16'h0065, '0, '0, '0, 6'h08, HDM_COND_START);
    blk <= 1'b1;
    fr(16'h0065, '0, '0, '0, 6'h00, HDM_COND_BLOCKED);
    blk <= 1'b0;
    fr(16'h0065, '0, '0, '0, 6'h08, HDM_COND_START);
    fr(16'h0065, '0, '0, '0, 6'h08, HDM_COND_START);
    fr(16'h0065, '0, '0, '0, 6'h09, HDM_COND_ALARM);
    wr(HDM_OFS_CTRL, 32'h0000_0100);
    fr(16'h0130, '0, 16'h013D, '0, 6'h12, HDM_COND_ALARM);
    fr('0, '0, '0, '0, 6'h00, HDM_COND_NORMAL);
    wr(HDM_OFS_CTRL, 32'h0000_0010);
    fr('0, '0, 16'h00C8, '0, 6'h00, HDM_COND_NORMAL);
    sel <= 1'b1;
    fr('0, '0, 16'h00C8, '0, 6'h12, HDM_COND_ALARM);
    md = HDM_MODE_OFF;
    wr(HDM_OFS_CTRL, 32'h0000_0016);
    fr('0, '0, 16'h00C8, '0, 6'h00, HDM_COND_NORMAL);
    md = HDM_MODE_BLK;
    wr(HDM_OFS_CTRL, 32'h0000_0011);
    fr('0, '0, 16'h00C8, '0, 6'h00, HDM_COND_BLOCKED);
    md = HDM_MODE_TEST;
    wr(HDM_OFS_CTRL, 32'h0000_0013);
    fr('0, '0, 16'h00C8, '0, 6'h12, HDM_COND_ALARM);
    md = HDM_MODE_TBLK;
    wr(HDM_OFS_CTRL, 32'h0000_0012);
    fr('0, '0, 16'h00C8, '0, 6'h00, HDM_COND_BLOCKED);
    s_axi_wstrb <= 4'h1;
    wr(HDM_OFS_THR_PH, 32'hFFFF_FF05);
    rd(HDM_OFS_THR_PH, 32'h0000_0305, 2'h0);
    summarize();
  end
endmodule // harmonic_distortion_alarm_monitor_test
`default_nettype wire
